// *** src/flash_cmd_sequencer.sv ***
// flash command sequencer: host accesses to the flash region become command triplets
// assumes host signals and timing settings are on core_clk_in; read data is sampled
// at the clock edge the latency setting names, no further synchronising
`timescale 1ns/100ps
`include "flash_seq_cfg.svh"
module flash_cmd_sequencer (
  // clock and reset
  input  wire logic                        core_clk_in,
  input  wire logic                        rst_in,
  // host request
  input  wire logic                        req_valid_in,
  input  wire logic                        req_write_in,
  input  wire logic [`ADDR_W-1:0]          req_addr_in,
  input  wire logic [`DATA_W-1:0]          req_wdata_in,
  input  wire logic                        refresh_req_in,
  // timing settings
  input  wire flash_seq_pkg::timing_type   timing_in,
  // host answer
  output logic                             busy_out,
  output logic                             done_out,
  output logic [`STATUS_W-1:0]             status_out,
  // memory bus
  output flash_seq_pkg::mem_bus_type       mem_out,
  input  wire logic [`DATA_W-1:0]          mem_rdata_in
);
  flash_seq_pkg::seq_regs_type r;
  flash_seq_pkg::seq_regs_type next_r;

  // a zero setting still costs one cycle so commands never collide
  function automatic logic [`DLY_W-1:0] wait_count(input logic [`DLY_W-1:0] d);
    wait_count = (d == '0) ? '0 : d - 4'h1;
  endfunction

  function automatic logic [`DLY_W-1:0] latency_count(input logic [1:0] cl);
    logic [1:0] c;
    c = (cl < `CL_MIN) ? `CL_MIN : cl;
    // read is registered at the end of its bus cycle, so data lands this many cycles on
    latency_count = {2'h0, c};
  endfunction

  function automatic flash_seq_pkg::mem_bus_type idle_bus();
    idle_bus = '0;
    idle_bus.cmd = flash_seq_pkg::CMD_NOP;
  endfunction

  function automatic logic [`BANK_W-1:0] bank_of(input logic [`ADDR_W-1:0] a);
    bank_of = a[`BANK_LSB +: `BANK_W];
  endfunction

  function automatic logic [`MA_W-1:0] row_of(input logic [`ADDR_W-1:0] a);
    row_of = a[`ROW_LSB +: `MA_W];
  endfunction

  // column sits on the low address lines, the upper lines idle at zero
  function automatic logic [`MA_W-1:0] col_of(input logic [`ADDR_W-1:0] a);
    col_of = `MA_W'(a[`COL_LSB +: `COL_W]);
  endfunction

  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.bus = idle_bus();
    if (refresh_req_in) begin
      next_r.ref_pending = 1'b1;
    end
    case (r.state)
      flash_seq_pkg::ST_IDLE: begin
        if (r.ref_pending) begin
          next_r.state = flash_seq_pkg::ST_REF;
        end else if (req_valid_in) begin
          next_r.busy = 1'b1;
          next_r.is_write = req_write_in;
          next_r.addr = req_addr_in;
          next_r.wdata = req_wdata_in;
          next_r.state = flash_seq_pkg::ST_LCR;
        end
      end
      flash_seq_pkg::ST_LCR: begin
        next_r.bus.cmd = flash_seq_pkg::CMD_LOAD_CMD_REG;
        next_r.bus.bank = bank_of(r.addr);
        next_r.bus.addr = row_of(r.addr);
        next_r.bus.addr[`OPC_MSB:`OPC_LSB] = r.is_write ? `OPC_PROGRAM
                                                        : `OPC_STATUS;
        next_r.count = wait_count(timing_in.row_cycle_delay);
        next_r.state = flash_seq_pkg::ST_LCR_WAIT;
      end
      flash_seq_pkg::ST_LCR_WAIT: begin
        if (r.count == '0) begin
          next_r.state = flash_seq_pkg::ST_ACT;
        end else begin
          next_r.count = r.count - 4'h1;
        end
      end
      flash_seq_pkg::ST_ACT: begin
        next_r.bus.cmd = flash_seq_pkg::CMD_ACTIVE;
        next_r.bus.bank = bank_of(r.addr);
        next_r.bus.addr = row_of(r.addr);
        next_r.count = wait_count(timing_in.row_to_column_delay);
        next_r.state = flash_seq_pkg::ST_RCD_WAIT;
      end
      flash_seq_pkg::ST_RCD_WAIT: begin
        if (r.count == '0) begin
          next_r.state = flash_seq_pkg::ST_RW;
        end else begin
          next_r.count = r.count - 4'h1;
        end
      end
      flash_seq_pkg::ST_RW: begin
        next_r.bus.bank = bank_of(r.addr);
        next_r.bus.addr = col_of(r.addr);
        if (r.is_write) begin
          // single word only; the flash takes no bursts so no terminate follows
          next_r.bus.cmd = flash_seq_pkg::CMD_WRITE;
          next_r.bus.wdata = r.wdata;
          next_r.bus.drive_data = 1'b1;
          next_r.count = wait_count(timing_in.precharge_delay);
          next_r.state = flash_seq_pkg::ST_PRE_WAIT;
        end else begin
          next_r.bus.cmd = flash_seq_pkg::CMD_READ;
          next_r.count = latency_count(timing_in.read_latency_cycles);
          next_r.state = flash_seq_pkg::ST_LAT_WAIT;
        end
      end
      flash_seq_pkg::ST_LAT_WAIT: begin
        if (r.count == '0) begin
          next_r.status = mem_rdata_in[`STATUS_W-1:0];
          next_r.busy = 1'b0;
          next_r.done = 1'b1;
          next_r.state = flash_seq_pkg::ST_IDLE;
        end else begin
          next_r.count = r.count - 4'h1;
        end
      end
      flash_seq_pkg::ST_PRE_WAIT: begin
        // no new active leaves idle before the precharge time has run
        if (r.count == '0) begin
          next_r.busy = 1'b0;
          next_r.done = 1'b1;
          next_r.state = flash_seq_pkg::ST_IDLE;
        end else begin
          next_r.count = r.count - 4'h1;
        end
      end
      flash_seq_pkg::ST_REF: begin
        next_r.bus.cmd = flash_seq_pkg::CMD_REFRESH;
        next_r.ref_pending = refresh_req_in;
        next_r.count = wait_count(timing_in.row_cycle_delay);
        next_r.state = flash_seq_pkg::ST_RC_WAIT;
      end
      flash_seq_pkg::ST_RC_WAIT: begin
        if (r.count == '0) begin
          next_r.state = flash_seq_pkg::ST_IDLE;
        end else begin
          next_r.count = r.count - 4'h1;
        end
      end
      default: begin
        next_r.state = flash_seq_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign busy_out = r.busy;
  assign done_out = r.done;
  assign status_out = r.status;
  assign mem_out = r.bus;
endmodule

// *** src/flash_seq_cfg.svh ***
// constants for the flash command sequencer
// assumes a single 125 MHz memory clock and an SDRAM-style command bus
`ifndef FLASH_SEQ_CFG_SVH
`define FLASH_SEQ_CFG_SVH
`define OPC_PROGRAM      8'h40
`define OPC_STATUS       8'h70
`define CLK_PERIOD_NS    8
`define ADDR_W           24
`define DATA_W           16
`define BANK_W           2
`define ROW_W            12
`define COL_W            9
`define MA_W             12
`define OPC_LSB          0
`define OPC_MSB          7
`define COL_LSB          1
`define ROW_LSB          10
`define BANK_LSB         22
`define STATUS_W         8
`define DLY_W            4
`define DLY_RESET        4'h3
`define CL_RESET         2'h2
`define CL_MIN           2'h1
`endif

// *** src/flash_seq_pkg.sv ***
// types shared by the flash command sequencer
// assumes flash_seq_cfg.svh supplies all widths except the 4-bit enums and the 2-bit latency field
`include "flash_seq_cfg.svh"
package flash_seq_pkg;
  typedef enum logic [3:0] {
    CMD_NOP, CMD_LOAD_CMD_REG, CMD_ACTIVE, CMD_READ, CMD_WRITE,
    CMD_PRECHARGE, CMD_REFRESH
  } mem_cmd_type;
  typedef enum logic [3:0] {
    ST_IDLE, ST_LCR, ST_LCR_WAIT, ST_ACT, ST_RCD_WAIT, ST_RW, ST_LAT_WAIT,
    ST_PRE_WAIT, ST_REF, ST_RC_WAIT
  } seq_state_type;
  typedef struct packed {
    mem_cmd_type             cmd;
    logic [`BANK_W-1:0]      bank;
    logic [`MA_W-1:0]        addr;
    logic [`DATA_W-1:0]      wdata;
    logic                    drive_data;
  } mem_bus_type;
  typedef struct packed {
    logic [`DLY_W-1:0]       row_to_column_delay;
    logic [`DLY_W-1:0]       precharge_delay;
    logic [`DLY_W-1:0]       row_cycle_delay;
    logic [1:0]              read_latency_cycles;
  } timing_type;
  typedef struct packed {
    seq_state_type           state;
    logic                    is_write;
    logic [`ADDR_W-1:0]      addr;
    logic [`DATA_W-1:0]      wdata;
    logic [`DLY_W-1:0]       count;
    mem_bus_type             bus;
    logic                    busy;
    logic                    done;
    logic [`STATUS_W-1:0]    status;
    logic                    ref_pending;
  } seq_regs_type;
endpackage

// *** test/flash_mem_model.sv ***
// flash model: answers a status read on the low data lines
// assumes the registered command bus and the latency setting of the sequencer
`timescale 1ns/100ps
`include "flash_seq_cfg.svh"
module flash_mem_model (
  input  wire logic                       core_clk_in,
  input  wire flash_seq_pkg::mem_bus_type mem_in,
  input  wire logic [1:0]                 cl_in,
  input  wire logic [`STATUS_W-1:0]       status_in,
  output logic [`DATA_W-1:0]              rdata_out
);
  logic [2:0]         pipe = 3'h0;
  logic [`DATA_W-1:0] junk = 16'h5A3C;
  wire logic [3:0]    hit = {pipe, mem_in.cmd == flash_seq_pkg::CMD_READ};
  always_ff @(posedge core_clk_in) begin
    pipe <= hit[2:0];
    junk <= ~junk;
  end
  // read is taken at the end of its bus cycle; the byte shows latency cycles later
  // bus churns outside the latency cycle so a stale byte never passes
  assign rdata_out = hit[(cl_in == 2'h0) ? 2'h1 : cl_in] ? {~status_in, status_in}
                                                         : junk;
endmodule

// *** test/flash_seq_monitor.sv ***
// checker: fields and spacing of the command triplets, status capture
// assumes one clock, rst_in synchronous and active high
`timescale 1ns/100ps
`include "flash_seq_cfg.svh"
module flash_seq_monitor (
  // clock and reset
  input  wire logic                       core_clk_in,
  input  wire logic                       rst_in,
  // host side
  input  wire logic                       req_valid_in,
  input  wire logic                       req_write_in,
  input  wire logic [`ADDR_W-1:0]         req_addr_in,
  input  wire logic [`DATA_W-1:0]         req_wdata_in,
  input  wire logic                       refresh_req_in,
  input  wire flash_seq_pkg::timing_type  timing_in,
  input  wire logic                       busy_out,
  input  wire logic                       done_out,
  input  wire logic [`STATUS_W-1:0]       status_out,
  // memory side
  input  wire flash_seq_pkg::mem_bus_type mem_out,
  input  wire logic [`DATA_W-1:0]         mem_rdata_in
);
  wire logic [3:0] c = mem_out.cmd;
  wire logic       lcr = c == flash_seq_pkg::CMD_LOAD_CMD_REG;
  wire logic       act = c == flash_seq_pkg::CMD_ACTIVE;
  wire logic       wrc = c == flash_seq_pkg::CMD_WRITE, rdc = c == flash_seq_pkg::CMD_READ;
  wire logic       rfc = c == flash_seq_pkg::CMD_REFRESH;
  wire logic [7:0] lo = mem_rdata_in[7:0];
  logic               wr;
  logic [`ADDR_W-1:0] a;
  logic [`DATA_W-1:0] d;
  logic [4:0]         sa, sw, sr, sf;
  function automatic logic [4:0] m1(input logic [3:0] v);
    return (v == 4'h0) ? 5'h01 : {1'b0, v};
  endfunction
  // copied on every idle edge, so the last copy is the request taken
  always_ff @(posedge core_clk_in) begin
    if (!busy_out) begin
      wr <= req_write_in;
      a <= req_addr_in;
      d <= req_wdata_in;
    end
    sa <= act ? 5'h01 : sa + 5'h01;
    sw <= wrc ? 5'h01 : sw + 5'h01;
    sr <= rdc ? 5'h01 : sr + 5'h01;
    // saturates so a long idle spell never wraps into a short gap
    if (rst_in) begin
      sf <= 5'h1F;
    end else begin
      sf <= rfc ? 5'h01 : sf + {4'h0, sf != 5'h1F};
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  a_lcr_opcode:
    assert property (lcr |-> mem_out.addr[7:0] == (wr ? `OPC_PROGRAM : `OPC_STATUS))
      else $error("bad opcode");
  a_lcr_bank:
    assert property (lcr |-> mem_out.bank == a[23:22]) else $error("bad lcr bank");
  a_act_row:
    assert property (act |-> mem_out.addr == a[21:10] && mem_out.bank == a[23:22])
      else $error("bad row");
  a_triplet_order:
    assert property (lcr |-> ##[1:16] act ##[1:16] (wr ? wrc : rdc)) else $error("bad order");
  // the command state after the wait costs one cycle more than the setting
  a_rcd_gap:
    assert property ((wrc || rdc) |-> sa == m1(timing_in.row_to_column_delay) + 5'h01)
      else $error("bad gap");
  a_single_word:
    assert property (wrc |-> mem_out.wdata == d && mem_out.drive_data ##1 c == 4'h0)
      else $error("bad word");
  a_pre_gap:
    assert property (done_out && wr |-> sw == m1(timing_in.precharge_delay))
      else $error("bad precharge");
  // byte taken latency cycles after the read, done shows one cycle later
  a_cl_gap:
    assert property (done_out && !wr |-> sr == m1({2'h0, timing_in.read_latency_cycles}) + 5'h01)
      else $error("bad latency");
  a_status_cap:
    assert property (done_out && !wr |-> status_out == $past(lo)) else $error("bad status");
  a_stall_done:
    assert property (done_out |-> !busy_out && $past(busy_out)) else $error("bad stall");
  a_ref_gap:
    assert property (lcr |-> sf >= m1(timing_in.row_cycle_delay)) else $error("bad refresh gap");
  c_write: cover property (wrc ##[1:16] done_out);
  c_read: cover property (rdc ##[1:8] done_out);
  c_refresh: cover property (refresh_req_in ##[1:100] rfc);
  c_take: cover property (req_valid_in && !busy_out ##1 busy_out);
endmodule
bind flash_cmd_sequencer flash_seq_monitor flash_seq_monitor_i (.*);

// *** test/test_synchronous_flash_cmd_sequencer.sv ***
// bench: program writes and status reads against the flash model
// assumes the checker is bound to the sequencer; one 125 MHz clock
`timescale 1ns/100ps
`include "flash_seq_cfg.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module test_synchronous_flash_cmd_sequencer;
  logic                       core_clk_in = 0, rst_in = 1, rv = 0, wr = 0, rf = 0, busy, done;
  logic [`ADDR_W-1:0]         ad = 24'h000000;
  logic [`DATA_W-1:0]         wd = 16'h0000, rdata;
  logic [`STATUS_W-1:0]       st = 8'h00, last = 8'h00, status, e;
  logic [`STATUS_W-1:0]       exp_q[$];
  flash_seq_pkg::timing_type  tm = 14'h0000;
  flash_seq_pkg::mem_bus_type mem;
  int                         seed = 83, n_fail = 0, checks_done = 0, n;
  always #4 core_clk_in = ~core_clk_in;
  flash_cmd_sequencer flash_cmd_sequencer_i (.core_clk_in, .rst_in, .req_valid_in(rv),
    .req_write_in(wr), .req_addr_in(ad), .req_wdata_in(wd), .refresh_req_in(rf),
    .timing_in(tm), .busy_out(busy), .done_out(done), .status_out(status),
    .mem_out(mem), .mem_rdata_in(rdata));
  flash_mem_model flash_mem_model_i (.core_clk_in, .mem_in(mem),
    .cl_in(tm.read_latency_cycles), .status_in(st), .rdata_out(rdata));
  // results come back in request order, so each done takes the oldest note
  always @(negedge core_clk_in) if (done === 1'b1) begin
    e = exp_q.size() ? exp_q.pop_front() : ~status;
    `CHK(busy, 1'b0)
    `CHK(status, e)
  end
  task automatic op(input logic w, input logic [1:0] cl, input logic r);
    @(posedge core_clk_in);
    #1;
    tm = 14'($random(seed));
    tm.read_latency_cycles = cl;
    {rv, wr, rf} = {1'b1, w, r};
    ad = 24'($random(seed));
    wd = 16'($random(seed));
    st = 8'($random(seed));
    if (!w) last = st;
    exp_q.push_back(last);
    // a pending refresh may delay the take, so hold until the triplet starts
    for (n = 0; mem.cmd !== flash_seq_pkg::CMD_LOAD_CMD_REG && n < 300; n++) begin
      @(posedge core_clk_in);
      #1 rf = 0;
    end
    if (mem.cmd !== flash_seq_pkg::CMD_LOAD_CMD_REG) n_fail++;
    rv = 0;
    for (n = 0; done !== 1'b1 && n < 300; n++) @(posedge core_clk_in) #1;
    if (done !== 1'b1) n_fail++;
    $display("test w=%0d cl=%0d ref=%0d over", w, cl, r);
  endtask
  task conclude;
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge core_clk_in);
    #1 rst_in = 0;
    for (int i = 0; i < 16; i++) op(i[2], i[1:0], i[3]);
    repeat (4) @(posedge core_clk_in);
    conclude();
  end
  initial begin
    #60000;
    n_fail++;
    conclude();
  end
endmodule
